//--- hdl/maint_chan_params.svh
`ifndef MAINT_CHAN_PARAMS_SVH
`define MAINT_CHAN_PARAMS_SVH

// Register byte offsets
`define OFS_COMMAND 8'h00
`define OFS_LOW_WORD 8'h04
`define OFS_HIGH_WORD 8'h08
`define OFS_SC2_WORD 8'h0C
`define OFS_STATUS 8'h10

// Command register bit positions (write one to issue)
`define CMD_SC1Q_MF_EN 0
`define CMD_SC2_MF_EN 1
`define CMD_SC1Q_MF_DIS 2
`define CMD_SC2_MF_DIS 3
`define CMD_VALID_ON 4
`define CMD_VALID_OFF 5
`define CMD_SIX_ON 6
`define CMD_SIX_OFF 7
`define CMD_SINGLE_ON 8

// Status register field positions
`define STS_RX_SC1Q_LSB 0
`define STS_RX_SC2_LSB 4
`define STS_FRAME_LSB 8
`define STS_REPEAT_LSB 16
`define STS_HP_FILL_LSB 20

// Reset values
`define RST_WORD 4'h0
`define RST_PRDATA 32'h0000_0000

// Line timing counts and high-priority buffer depth
`define FRAMES_PER_MF 20
`define FA_PERIOD 5
`define SIX_REPEATS 6
`define VALID_REPEATS 3
`define HP_DEPTH 2

`endif

//--- hdl/maint_chan_pkg.sv
package maint_chan_pkg;

	typedef struct packed {
		logic valid;
		logic [3:0] sc1q;
		logic [3:0] sc2;
	} rx_words_t;

	typedef struct packed {
		logic fa_invert;
		logic m_bit;
		logic [3:0] sc1q;
		logic [3:0] sc2;
	} tx_bits_t;

	typedef struct packed {
		logic sc1q_mf_en;
		logic sc2_mf_en;
		logic validate_on;
		logic six_on;
		logic single_on;
	} ctrl_t;

endpackage

//--- hdl/maint_chan.sv
// Notes on behaviour
// - Maintenance words are four bits, one per twenty-frame multiframe, 800 bit/s.
// - Each multiframe carries one SC1 word downstream and one Q word upstream.
// - Downstream also has SC2 to SC5 sub-channels; SC2 is sent here.
// - NT enable sends FA reversal every fifth frame, M every twentieth; unmasks interrupt.
// - Identification pattern only while transmitting INFO 2 or INFO 4.
// - In TE modes enable only unmasks the receive interrupt.
// - Disable stops NT pattern and masks receive interrupts in all modes.
// - Validation switched on and off by its two commands.
// - Validation decodes at multiframe end: interrupt now or after three equal words.
// - After a triple-checked interrupt, none until the received word changes.
// - Violation, power-loss and undefined SC1/Q codes interrupt after one reception.
// - Every SC2 word needs three identical receptions before its interrupt.
// - With validation off, any received word change interrupts at once.
// - Received codes cause only interrupts, no other action.
// - Low-priority word sent continually; high-priority word sent once.
// - High-priority register holds two loads; controller limits three per 10 ms.
// - Six counter interrupts every six multiframes and repeats low word six times.
// - Single counter interrupts every multiframe and disables six-times logic.
// - With both counters on, the single counter wins.
// - New low word starts at next six boundary; otherwise old word repeats.
// - High word goes out on next boundary, then low word resumes.
// - SC2 word starts on next six boundary and recycles if not reloaded.
`timescale 1ns/10ps
`include "maint_chan_params.svh"

module rx_validator (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic strobe,
	input wire logic [3:0] word,
	input wire logic validate_on,
	input wire logic irq_enable,
	input wire logic single_code,
	output logic irq,
	output logic [3:0] last_word
);
	logic [1:0] count_reg, count_next;
	logic reported_reg, reported_next;
	logic irq_next;
	logic [3:0] last_next;

	always_comb begin
		count_next = count_reg;
		reported_next = reported_reg;
		last_next = last_word;
		irq_next = 1'b0;
		if (strobe) begin
			last_next = word;
			if (!validate_on) begin
				irq_next = (word != last_word);
				count_next = 2'd1;
				reported_next = 1'b0;
			end else if (word != last_word) begin
				count_next = 2'd1;
				reported_next = single_code;
				irq_next = single_code;
			end else begin
				if (count_reg != 2'(`VALID_REPEATS))
					count_next = count_reg + 2'd1;
				if (!reported_reg && count_next == 2'(`VALID_REPEATS)) begin
					irq_next = 1'b1;
					reported_next = 1'b1;
				end
			end
			irq_next = irq_next & irq_enable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 2'd0;
			reported_reg <= 1'b0;
			last_word <= `RST_WORD;
			irq <= 1'b0;
		end else begin
			count_reg <= count_next;
			reported_reg <= reported_next;
			last_word <= last_next;
			irq <= irq_next;
		end
	end

	a_triple_raises_irq: assert property (@(posedge pclk) disable iff (!presetn)
		strobe && validate_on && irq_enable && word == last_word && !reported_reg
		&& count_reg == 2'd2 |=> irq)
		else $error("third identical word did not interrupt");

	a_steady_word_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		strobe && !validate_on && word == last_word |=> !irq)
		else $error("unchanged word interrupted with validation off");
endmodule

module maint_chan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nt_mode,
	input wire logic tx_info_active,
	input wire logic frame_tick,
	input wire maint_chan_pkg::rx_words_t rx_words,
	output maint_chan_pkg::tx_bits_t tx_bits,
	output logic sc1q_receive_irq,
	output logic sc2_receive_irq,
	output logic repeat_counter_irq
);
	maint_chan_pkg::ctrl_t ctrl_reg, ctrl_next;
	logic [3:0] low_priority_tx_word, low_next;
	logic [3:0] sc2_tx_word, sc2_next;
	logic [3:0] high_buf_reg [`HP_DEPTH];
	logic [3:0] high_buf_next [`HP_DEPTH];
	logic [1:0] hp_fill_reg, hp_fill_next;
	logic [4:0] frame_reg, frame_next;
	logic [2:0] fa_reg, fa_next;
	logic [2:0] repeat_reg, repeat_next;
	logic [3:0] low_cur_reg, low_cur_next;
	logic [3:0] sc2_cur_reg, sc2_cur_next;
	maint_chan_pkg::tx_bits_t tx_next;
	logic rep_irq_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;
	logic access, wr_en, hp_write, boundary, six_boundary, six_active, pattern_on;
	logic [3:0] sc1q_last, sc2_last;
	logic sc1q_single;

	function automatic logic single_check(input logic nt, input logic [3:0] w);
		if (nt)
			return !(w inside {4'hF, 4'h1, 4'h7, 4'hB, 4'h3});
		return !(w inside {4'h0, 4'h2, 4'h1, 4'h7, 4'h3, 4'hD, 4'hB, 4'h9, 4'hA});
	endfunction

	assign access = psel && penable && pready;
	assign wr_en = access && pwrite;
	assign hp_write = wr_en && paddr == `OFS_HIGH_WORD;
	assign boundary = frame_tick && frame_reg == 5'(`FRAMES_PER_MF - 1);
	assign six_boundary = boundary && repeat_reg == 3'd0;
	assign six_active = ctrl_reg.six_on && !ctrl_reg.single_on;
	// pattern only in NT, during INFO 2 or 4
	assign pattern_on = nt_mode && tx_info_active && ctrl_reg.sc1q_mf_en;
	assign sc1q_single = single_check(nt_mode, rx_words.sc1q);

	// Command and register writes
	always_comb begin
		ctrl_next = ctrl_reg;
		low_next = low_priority_tx_word;
		sc2_next = sc2_tx_word;
		if (wr_en && paddr == `OFS_COMMAND) begin
			// enable and disable commands, disable wins
			ctrl_next.sc1q_mf_en = (ctrl_reg.sc1q_mf_en | pwdata[`CMD_SC1Q_MF_EN])
				& !pwdata[`CMD_SC1Q_MF_DIS];
			ctrl_next.sc2_mf_en = (ctrl_reg.sc2_mf_en | pwdata[`CMD_SC2_MF_EN])
				& !pwdata[`CMD_SC2_MF_DIS];
			ctrl_next.validate_on = (ctrl_reg.validate_on | pwdata[`CMD_VALID_ON])
				& !pwdata[`CMD_VALID_OFF];
			ctrl_next.six_on = (ctrl_reg.six_on | pwdata[`CMD_SIX_ON])
				& !pwdata[`CMD_SIX_OFF];
			ctrl_next.single_on = ctrl_reg.single_on | pwdata[`CMD_SINGLE_ON];
		end
		if (wr_en && paddr == `OFS_LOW_WORD)
			low_next = pwdata[3:0];
		if (wr_en && paddr == `OFS_SC2_WORD)
			sc2_next = pwdata[3:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= '0;
			low_priority_tx_word <= `RST_WORD;
			sc2_tx_word <= `RST_WORD;
		end else begin
			ctrl_reg <= ctrl_next;
			low_priority_tx_word <= low_next;
			sc2_tx_word <= sc2_next;
		end
	end

	// Line side: framing, repetition and transmit words
	always_comb begin
		frame_next = frame_reg;
		fa_next = fa_reg;
		repeat_next = repeat_reg;
		low_cur_next = low_cur_reg;
		sc2_cur_next = sc2_cur_reg;
		tx_next = tx_bits;
		rep_irq_next = 1'b0;
		high_buf_next = high_buf_reg;
		hp_fill_next = hp_fill_reg;
		if (frame_tick) begin
			frame_next = boundary ? 5'd0 : frame_reg + 5'd1;
			fa_next = (fa_reg == 3'(`FA_PERIOD - 1)) || boundary ? 3'd0 : fa_reg + 3'd1;
			tx_next.fa_invert = pattern_on && fa_next == 3'd0;
			tx_next.m_bit = pattern_on && frame_next == 5'd0;
		end
		if (boundary) begin
			repeat_next = (repeat_reg == 3'(`SIX_REPEATS - 1)) ? 3'd0 : repeat_reg + 3'd1;
			if (ctrl_reg.single_on)
				rep_irq_next = 1'b1;
			else if (ctrl_reg.six_on)
				rep_irq_next = six_boundary;
			if (six_boundary || !six_active) begin
				low_cur_next = low_priority_tx_word;
				sc2_cur_next = sc2_tx_word;
			end
			tx_next.sc2 = (six_boundary || !six_active) ? sc2_tx_word : sc2_cur_reg;
			// high word once, else low word
			if (hp_fill_reg != 2'd0) begin
				tx_next.sc1q = high_buf_reg[0];
				high_buf_next[0] = high_buf_reg[1];
				hp_fill_next = hp_fill_reg - 2'd1;
			end else begin
				tx_next.sc1q = (six_boundary || !six_active) ? low_priority_tx_word
					: low_cur_reg;
			end
		end
		// two-deep high-priority buffer; a load into a full buffer is dropped unless a word goes out in that cycle
		if (hp_write && hp_fill_next != 2'(`HP_DEPTH)) begin
			high_buf_next[hp_fill_next[0]] = pwdata[3:0];
			hp_fill_next = hp_fill_next + 2'd1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_reg <= 5'd0;
			fa_reg <= 3'd0;
			repeat_reg <= 3'd0;
			low_cur_reg <= `RST_WORD;
			sc2_cur_reg <= `RST_WORD;
			tx_bits <= '0;
			repeat_counter_irq <= 1'b0;
			high_buf_reg[0] <= `RST_WORD;
			high_buf_reg[1] <= `RST_WORD;
			hp_fill_reg <= 2'd0;
		end else begin
			frame_reg <= frame_next;
			fa_reg <= fa_next;
			repeat_reg <= repeat_next;
			low_cur_reg <= low_cur_next;
			sc2_cur_reg <= sc2_cur_next;
			tx_bits <= tx_next;
			repeat_counter_irq <= rep_irq_next;
			high_buf_reg <= high_buf_next;
			hp_fill_reg <= hp_fill_next;
		end
	end

	// receive words only raise gated interrupts
	rx_validator sc1q_check (
		.pclk(pclk),
		.presetn(presetn),
		.strobe(rx_words.valid),
		.word(rx_words.sc1q),
		.validate_on(ctrl_reg.validate_on),
		.irq_enable(ctrl_reg.sc1q_mf_en),
		.single_code(sc1q_single),
		.irq(sc1q_receive_irq),
		.last_word(sc1q_last)
	);

	rx_validator sc2_check (
		.pclk(pclk),
		.presetn(presetn),
		.strobe(rx_words.valid),
		.word(rx_words.sc2),
		.validate_on(ctrl_reg.validate_on),
		.irq_enable(ctrl_reg.sc2_mf_en),
		.single_code(1'b0),
		.irq(sc2_receive_irq),
		.last_word(sc2_last)
	);

	// APB slave: one wait state, error on unmapped address
	always_comb begin
		pready_next = psel && penable && !pready;
		prdata_next = prdata;
		pslverr_next = 1'b0;
		if (pready_next) begin
			prdata_next = `RST_PRDATA;
			case (paddr)
				`OFS_COMMAND: prdata_next = {27'h0, ctrl_reg};
				`OFS_LOW_WORD: prdata_next = {28'h0, low_priority_tx_word};
				`OFS_HIGH_WORD: prdata_next = {28'h0, high_buf_reg[0]};
				`OFS_SC2_WORD: prdata_next = {28'h0, sc2_tx_word};
				`OFS_STATUS: begin
					prdata_next[`STS_RX_SC1Q_LSB +: 4] = sc1q_last;
					prdata_next[`STS_RX_SC2_LSB +: 4] = sc2_last;
					prdata_next[`STS_FRAME_LSB +: 5] = frame_reg;
					prdata_next[`STS_REPEAT_LSB +: 3] = repeat_reg;
					prdata_next[`STS_HP_FILL_LSB +: 2] = hp_fill_reg;
				end
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `RST_PRDATA;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	sequence hp_pending_at_boundary;
		boundary && hp_fill_reg != 2'd0;
	endsequence

	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait");
	a_m_bit_place: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bits.m_bit |-> frame_reg == 5'd0)
		else $error("M bit outside the first frame");
	a_pattern_gated: assert property (@(posedge pclk) disable iff (!presetn)
		frame_tick && !pattern_on |=> !tx_bits.m_bit && !tx_bits.fa_invert)
		else $error("identification pattern sent while not allowed");
	a_high_sent_once: assert property (@(posedge pclk) disable iff (!presetn)
		hp_pending_at_boundary |=> tx_bits.sc1q == $past(high_buf_reg[0])
		&& hp_fill_reg == $past(hp_fill_reg) - 2'd1 + 2'($past(hp_write)))
		else $error("high word not sent once at boundary");
	a_low_direct: assert property (@(posedge pclk) disable iff (!presetn)
		boundary && hp_fill_reg == 2'd0 && !six_active
		|=> tx_bits.sc1q == $past(low_priority_tx_word))
		else $error("low word not sent at boundary");
	a_single_counter: assert property (@(posedge pclk) disable iff (!presetn)
		boundary && ctrl_reg.single_on |=> repeat_counter_irq)
		else $error("single counter interrupt missing");
	a_six_counter_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		boundary && six_active && repeat_reg != 3'd0 |=> !repeat_counter_irq
		##1 !repeat_counter_irq)
		else $error("six counter interrupted off its boundary");
	a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_reg.sc2_mf_en |=> !sc2_receive_irq)
		else $error("masked SC2 interrupt fired");
	a_hp_overflow: assert property (@(posedge pclk) disable iff (!presetn)
		hp_fill_reg == 2'd2 && !boundary |=> hp_fill_reg == 2'd2)
		else $error("full high buffer changed without a send");
endmodule

//--- tb/line_partner.sv
`timescale 1ns/10ps
module line_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] sc1q_word,
	input wire logic [3:0] sc2_word,
	output logic frame_tick,
	output maint_chan_pkg::rx_words_t rx_words
);
	logic [5:0] phase_reg;
	logic [5:0] phase_next;
	logic [7:0] held_reg;
	logic [7:0] held_next;
	logic end_of_mf;

	always_comb begin
		end_of_mf = (phase_reg == 6'h27);
		phase_next = end_of_mf ? 6'h00 : phase_reg + 6'h01;
		held_next = end_of_mf ? {sc1q_word, sc2_word} : held_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 6'h00;
			held_reg <= 8'h00;
		end else begin
			phase_reg <= phase_next;
			held_reg <= held_next;
		end
	end

	assign frame_tick = phase_reg[0];

	always_comb begin
		rx_words.valid = end_of_mf;
		rx_words.sc1q = end_of_mf ? sc1q_word : ~held_reg[7:4];
		rx_words.sc2 = end_of_mf ? sc2_word : ~held_reg[3:0];
	end
endmodule

//--- tb/maint_chan_test.sv
`timescale 1ns/10ps
`include "maint_chan_params.svh"
module maint_chan_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data;
	logic pready, pslverr, rd_err, frame_tick;
	logic nt_mode = 1'b1, tx_info_active = 1'b1;
	logic [3:0] sc1q_word = 4'h0, sc2_word = 4'h0;
	maint_chan_pkg::rx_words_t rx_words;
	maint_chan_pkg::tx_bits_t tx_bits;
	logic sc1q_receive_irq, sc2_receive_irq, repeat_counter_irq;
	logic [4:0] mon, mon_q = 5'h00;
	logic [7:0] cnt [5] = '{default: 8'h00};
	logic [7:0] snap [5];
	logic [47:0] hist = 48'h0;
	int cyc = 0, mark = 0, err_total = 0, samples_checked = 0;

	always #5 pclk = ~pclk;

	maint_chan maint_chan_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nt_mode(nt_mode), .tx_info_active(tx_info_active),
		.frame_tick(frame_tick), .rx_words(rx_words), .tx_bits(tx_bits),
		.sc1q_receive_irq(sc1q_receive_irq), .sc2_receive_irq(sc2_receive_irq),
		.repeat_counter_irq(repeat_counter_irq));

	line_partner line_partner_inst (.pclk(pclk), .presetn(presetn), .sc1q_word(sc1q_word),
		.sc2_word(sc2_word), .frame_tick(frame_tick), .rx_words(rx_words));

	assign mon = {tx_bits.m_bit, tx_bits.fa_invert, sc1q_receive_irq, sc2_receive_irq,
		repeat_counter_irq};

	always @(posedge pclk) begin
		mon_q <= mon;
		cyc <= cyc + 1;
		for (int i = 0; i < 5; i++) begin
			if (mon[i] && !mon_q[i]) cnt[i] <= cnt[i] + 8'h01;
		end
		if (mon[4] && !mon_q[4]) hist <= {hist[39:0], tx_bits.sc1q, tx_bits.sc2};
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_counts(input logic [39:0] exp);
		for (int i = 0; i < 5; i++) begin
			check("event count", 48'(exp[8*i +: 8]), 48'(cnt[i] - snap[i]));
			snap[i] = cnt[i];
		end
	endtask

	task automatic wait_mf(input int n);
		mark = mark + n * 40;
		while (cyc < mark) @(negedge pclk);
	endtask

	task automatic sync_on(input logic rep);
		if (rep) @(posedge pclk iff repeat_counter_irq);
		else @(posedge pclk iff rx_words.valid);
		mark = cyc + 3;
		wait_mf(0);
		snap = cnt;
	endtask

	task automatic set_line(input logic nt, input logic info, input logic [3:0] a,
		input logic [3:0] b);
		@(posedge pclk);
		nt_mode <= nt;
		tx_info_active <= info;
		sc1q_word <= a;
		sc2_word <= b;
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge pclk);
		err_total++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFS_COMMAND, 32'h0);
		check("command", 48'h0, 48'(rd_data));
		apb(1'b0, `OFS_STATUS, 32'h0);
		// Frame field has counted three line frames by this read
		check("status", 48'h300, 48'(rd_data));
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		check("unmapped error", 48'h1, 48'(rd_err));
		sync_on(1'b0);
		wait_mf(1);
		check_counts(40'h00_00_00_00_00);
		apb(1'b1, `OFS_LOW_WORD, 32'h3);
		apb(1'b1, `OFS_SC2_WORD, 32'h5);
		apb(1'b1, `OFS_COMMAND, 32'h3);
		apb(1'b0, `OFS_COMMAND, 32'h0);
		check("command", 48'h18, 48'(rd_data));
		set_line(1'b1, 1'b0, 4'h7, 4'hA);
		wait_mf(1);
		check_counts(40'h00_00_01_01_00);
		set_line(1'b0, 1'b1, 4'h7, 4'hA);
		wait_mf(1);
		check_counts(40'h00_00_00_00_00);
		set_line(1'b1, 1'b1, 4'h7, 4'hA);
		wait_mf(2);
		check_counts(40'h02_08_00_00_00);
		check("sent words", 48'h35, 48'(hist[7:0]));
		apb(1'b1, `OFS_COMMAND, 32'h10);
		set_line(1'b1, 1'b1, 4'h1, 4'h6);
		wait_mf(2);
		check_counts(40'h02_08_00_00_00);
		wait_mf(1);
		check_counts(40'h01_04_01_01_00);
		wait_mf(2);
		check_counts(40'h02_08_00_00_00);
		for (int i = 0; i < 2; i++) begin
			set_line(1'b1, 1'b1, i ? 4'h5 : 4'h0, 4'h6);
			wait_mf(1);
			check_counts(40'h01_04_01_00_00);
		end
		check("sent words", 48'h35, 48'(hist[7:0]));
		// Terminal side: loss of power is a single-reception code
		set_line(1'b0, 1'b1, 4'hF, 4'h6);
		wait_mf(1);
		check_counts(40'h00_00_01_00_00);
		apb(1'b1, `OFS_COMMAND, 32'h0C);
		set_line(1'b1, 1'b1, 4'hE, 4'h9);
		wait_mf(3);
		check_counts(40'h00_00_00_00_00);
		apb(1'b1, `OFS_COMMAND, 32'h23);
		apb(1'b1, `OFS_HIGH_WORD, 32'hE);
		apb(1'b1, `OFS_HIGH_WORD, 32'hD);
		apb(1'b0, `OFS_STATUS, 32'h0);
		check("high fill", 48'h2, 48'(rd_data[21:20]));
		wait_mf(4);
		check("sent words", 48'hE5_D5_35_35, 48'(hist[31:0]));
		check_counts(40'h04_10_00_00_00);
		apb(1'b1, `OFS_COMMAND, 32'h40);
		sync_on(1'b1);
		apb(1'b1, `OFS_LOW_WORD, 32'h9);
		apb(1'b1, `OFS_SC2_WORD, 32'hB);
		wait_mf(6);
		check("sent words", 48'h35_35_35_35_35_9B, hist);
		check_counts(40'h06_18_00_00_01);
		apb(1'b1, `OFS_LOW_WORD, 32'h6);
		wait_mf(6);
		check("sent words", 48'h9B_9B_9B_9B_9B_6B, hist);
		check_counts(40'h06_18_00_00_01);
		apb(1'b1, `OFS_COMMAND, 32'h80);
		wait_mf(6);
		check_counts(40'h06_18_00_00_00);
		apb(1'b1, `OFS_COMMAND, 32'h140);
		apb(1'b1, `OFS_LOW_WORD, 32'h2);
		wait_mf(2);
		check_counts(40'h02_08_00_00_02);
		check("sent words", 48'h2B, 48'(hist[7:0]));
		end_of_test();
	end
endmodule
